// ==== sce_cmd_enable.sv ====
// Purpose: Serial-bus command decoder and power/function enable register
// Assumes: sys_clk at 10 MHz, bus clock far slower; events on sys_clk
// Notes: Only the enable and status registers are held here
//
// Operation
// - Bits 6:5 give transfer type; 10 unused
// - Type 00 keeps the same register address
// - Type 01 advances address after each byte
// - Bits 4:0 are address or special code
// - Codes 5,6,7 clear prox, light, both pending
// - Code 0 does nothing; other codes unused
// - Interrupt clear leaves no bit set behind; here an event in the same cycle keeps its flag set
// - Proximity interrupts only while its allow bit set
// - Light interrupts only while its allow bit set
// - Enable bit 3 turns wait timer on/off
// - Enable bit 2 turns proximity on/off
// - Enable bit 1 turns light converter on/off
// - Enable bit 0 runs the oscillator
// - Fixed 2.72 ms delay before converter cycle
// - Light converter needs its bit and power bit
// - Bus activity forces the oscillator on
// - Hardware holds measurements 2.72 ms after power-on
// - Byte with clear top bit is data
// - Respond at target address 0x39 only
`include "sce_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sce_cmd_enable #(
  parameter int HOLDOFF_CYC = `SCE_HOLDOFF_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic prox_event,
  input wire logic light_event,
  output logic osc_run,
  output logic wait_run,
  output logic prox_run,
  output logic light_adc_run,
  output logic meas_ready,
  output logic irq_out
);

  // Synchronised bus lines and their previous samples
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;

  // Bus engine state
  sce_pkg::sce_bus_state_t state_q;
  logic [3:0] cnt_q;       // Bits moved in the current byte
  logic [7:0] shift_q;     // Receive or transmit shifter
  logic addr_phase_q;      // Next byte is the target address
  logic cmd_slot_q;        // Next written byte may be a command
  logic tx_next_q;         // After this acknowledge, send data
  logic nack_q;            // Host refused the last sent byte
  logic busy_q;            // Between start and stop

  // Command state and registers
  logic [4:0] reg_addr_q;  // Stored register address
  logic [1:0] xfer_type_q; // Stored transfer type
  logic [7:0] enable_q;    // Power and function enable register
  logic prox_pend_q;       // Pending proximity interrupt
  logic light_pend_q;      // Pending light interrupt

  // Power-up hold-off counter
  logic [$clog2(HOLDOFF_CYC+1)-1:0] hold_cnt_q;

  // Pins cross into sys_clk through two flops each
  sce_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(scl_in),
    .sync_out(scl_s)
  );

  sce_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(sda_in),
    .sync_out(sda_s)
  );

  // Previous samples for edge and condition detection
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Bus events, all on synchronised samples
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Decoded byte-complete events
  logic byte_done;
  logic addr_hit;
  logic cmd_ev;
  logic data_wr_ev;
  logic rd_done_ev;
  assign byte_done = (state_q == sce_pkg::SCE_RX) && scl_fall &&
                     (cnt_q == 4'h8);
  assign addr_hit = byte_done && addr_phase_q &&
                    (shift_q[7:1] == `SCE_TARGET_ADDR);
  // Top bit set in the command slot makes it a command
  assign cmd_ev = byte_done && !addr_phase_q && cmd_slot_q &&
                  shift_q[`SCE_CMD_SELECT];
  // Anything else written after the address is data
  assign data_wr_ev = byte_done && !addr_phase_q && !cmd_ev;
  assign rd_done_ev = (state_q == sce_pkg::SCE_TXACK) && scl_rise;

  // Command field views
  logic [1:0] cmd_type;
  logic [4:0] cmd_field;
  assign cmd_type = shift_q[`SCE_CMD_TYPE_HI:`SCE_CMD_TYPE_LO];
  assign cmd_field = shift_q[4:0];

  // Special function decoded from the command byte
  logic sf_ev;
  logic clr_prox;
  logic clr_light;
  assign sf_ev = cmd_ev && (cmd_type == `SCE_TYPE_SPECIAL);
  // Codes outside the defined set, including no-op, do nothing
  assign clr_prox = sf_ev && ((cmd_field == `SCE_SF_CLR_PROX) ||
                    (cmd_field == `SCE_SF_CLR_BOTH));
  assign clr_light = sf_ev && ((cmd_field == `SCE_SF_CLR_LIGHT) ||
                     (cmd_field == `SCE_SF_CLR_BOTH));

  // Read data for the stored address; unmapped reads give zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (reg_addr_q)
      `SCE_ENABLE_ADDR: rd_byte = enable_q;
      `SCE_STATUS_ADDR: begin
        rd_byte[`SCE_ST_PROX_PEND] = prox_pend_q;
        rd_byte[`SCE_ST_LIGHT_PEND] = light_pend_q;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus engine: start, address, acknowledge, receive and send
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= sce_pkg::SCE_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      addr_phase_q <= 1'b0;
      cmd_slot_q <= 1'b0;
      tx_next_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_ev) begin
      // A start, repeated or not, always restarts the address phase
      state_q <= sce_pkg::SCE_RX;
      cnt_q <= 4'h0;
      addr_phase_q <= 1'b1;
      sda_oe <= 1'b0;
    end else if (stop_ev) begin
      state_q <= sce_pkg::SCE_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_q)
        sce_pkg::SCE_IDLE: begin
          sda_oe <= 1'b0;
        end
        sce_pkg::SCE_RX: begin
          if (scl_rise && cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            if (addr_phase_q) begin
              // Foreign address: drop off the bus until the next start
              if (addr_hit) begin
                state_q <= sce_pkg::SCE_ACK;
                sda_oe <= 1'b1;
                tx_next_q <= shift_q[0];
                cmd_slot_q <= ~shift_q[0];
              end else begin
                state_q <= sce_pkg::SCE_IDLE;
              end
              addr_phase_q <= 1'b0;
            end else begin
              // Only the first written byte may be a command
              state_q <= sce_pkg::SCE_ACK;
              sda_oe <= 1'b1;
              tx_next_q <= 1'b0;
              cmd_slot_q <= 1'b0;
            end
          end
        end
        sce_pkg::SCE_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (tx_next_q) begin
              state_q <= sce_pkg::SCE_TX;
              shift_q <= rd_byte;
              sda_oe <= ~rd_byte[7];
              cnt_q <= 4'h1;
            end else begin
              state_q <= sce_pkg::SCE_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        sce_pkg::SCE_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              state_q <= sce_pkg::SCE_TXACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~shift_q[6];
              shift_q <= {shift_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        sce_pkg::SCE_TXACK: begin
          if (scl_rise) begin
            nack_q <= sda_s;
          end else if (scl_fall) begin
            // Refused byte ends the read; wait for stop or start
            if (nack_q) begin
              state_q <= sce_pkg::SCE_IDLE;
            end else begin
              state_q <= sce_pkg::SCE_TX;
              shift_q <= rd_byte;
              sda_oe <= ~rd_byte[7];
              cnt_q <= 4'h1;
            end
          end
        end
        default: begin
          state_q <= sce_pkg::SCE_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data: the pin is only ever pulled low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Bus busy between start and stop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else if (start_ev) begin
      busy_q <= 1'b1;
    end else if (stop_ev) begin
      busy_q <= 1'b0;
    end
  end

  // Stored address and transfer type
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_addr_q <= 5'h00;
      xfer_type_q <= `SCE_TYPE_REPEAT;
    end else if (cmd_ev) begin
      // Reserved type is ignored; special keeps the stored address
      if (cmd_type == `SCE_TYPE_REPEAT ||
          cmd_type == `SCE_TYPE_AUTOINC) begin
        reg_addr_q <= cmd_field;
        xfer_type_q <= cmd_type;
      end
    end else if ((data_wr_ev || rd_done_ev) &&
                 xfer_type_q == `SCE_TYPE_AUTOINC) begin
      reg_addr_q <= reg_addr_q + 5'h01;
    end
    // Repeated-byte type leaves the address untouched
  end

  // Enable register; reserved bits are never stored
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      enable_q <= `SCE_ENABLE_RST;
    end else if (data_wr_ev && reg_addr_q == `SCE_ENABLE_ADDR) begin
      enable_q <= shift_q & `SCE_ENABLE_MASK;
    end
  end

  // Pending flags: event wins over clear in the same cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prox_pend_q <= 1'b0;
      light_pend_q <= 1'b0;
    end else begin
      if (prox_event && enable_q[`SCE_EN_PROX_IRQ]) begin
        prox_pend_q <= 1'b1;
      end else if (clr_prox) begin
        prox_pend_q <= 1'b0;
      end
      if (light_event && enable_q[`SCE_EN_LIGHT_IRQ]) begin
        light_pend_q <= 1'b1;
      end else if (clr_light) begin
        light_pend_q <= 1'b0;
      end
    end
  end

  // Hold-off restarts whenever power is removed
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hold_cnt_q <= '0;
    end else if (!enable_q[`SCE_EN_OSC]) begin
      hold_cnt_q <= '0;
    end else if (hold_cnt_q != HOLDOFF_CYC[$bits(hold_cnt_q)-1:0]) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  // Function outputs; measurements wait out the hold-off
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      osc_run <= 1'b0;
      meas_ready <= 1'b0;
      wait_run <= 1'b0;
      prox_run <= 1'b0;
      light_adc_run <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      osc_run <= enable_q[`SCE_EN_OSC] | busy_q;
      meas_ready <= enable_q[`SCE_EN_OSC] &&
        (hold_cnt_q == HOLDOFF_CYC[$bits(hold_cnt_q)-1:0]);
      wait_run <= enable_q[`SCE_EN_WAIT] & meas_ready;
      prox_run <= enable_q[`SCE_EN_PROX] & meas_ready;
      light_adc_run <= enable_q[`SCE_EN_LIGHT] &
        enable_q[`SCE_EN_OSC] & meas_ready;
      irq_out <= (prox_pend_q & enable_q[`SCE_EN_PROX_IRQ]) |
        (light_pend_q & enable_q[`SCE_EN_LIGHT_IRQ]);
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  addr_ignore_a: assert property (byte_done && addr_phase_q &&
    shift_q[7:1] != `SCE_TARGET_ADDR |=> state_q == sce_pkg::SCE_IDLE
    && !sda_oe) else $error("Foreign address acknowledged");
  addr_keep_a: assert property (data_wr_ev &&
    xfer_type_q == `SCE_TYPE_REPEAT |=> $stable(reg_addr_q))
    else $error("Repeated-byte address moved");
  addr_step_a: assert property (data_wr_ev &&
    xfer_type_q == `SCE_TYPE_AUTOINC |=>
    reg_addr_q == $past(reg_addr_q) + 5'h01)
    else $error("Auto-increment missed");
  cmd_load_a: assert property (cmd_ev &&
    cmd_type == `SCE_TYPE_AUTOINC |=> reg_addr_q == $past(cmd_field) &&
    xfer_type_q == 2'b01) else $error("Command address not stored");
  // A byte with its top bit clear, with address 0 stored, must land in the enable register
  data_path_a: assert property (byte_done && !addr_phase_q &&
    !shift_q[7] && reg_addr_q == 5'h00 |=> enable_q == ($past(shift_q)
    & `SCE_ENABLE_MASK)) else $error("Data byte not stored");
  // An event one cycle after the clear may legally set the flag again
  clr_prox_a: assert property (clr_prox && !prox_event |=>
    !prox_pend_q ##1 (!prox_pend_q || $past(prox_event)))
    else $error("Proximity clear failed");
  noop_sf_a: assert property (sf_ev && cmd_field == `SCE_SF_NONE |=>
    $stable(reg_addr_q) && (prox_pend_q || !$past(prox_pend_q)))
    else $error("No-op command acted");
  prox_gate_a: assert property (!enable_q[`SCE_EN_PROX_IRQ] &&
    !prox_pend_q |=> !prox_pend_q)
    else $error("Proximity flag set while barred");
  light_gate_a: assert property (!enable_q[`SCE_EN_LIGHT_IRQ] &&
    !light_pend_q |=> !light_pend_q)
    else $error("Light flag set while barred");
  osc_force_a: assert property (busy_q |=> osc_run)
    else $error("Oscillator not forced during access");
  power_hold_a: assert property ($rose(enable_q[`SCE_EN_OSC]) |=>
    !meas_ready [*8]) else $error("Hold-off too short");
  light_needs_a: assert property (light_adc_run |->
    $past(enable_q[`SCE_EN_OSC]) && $past(enable_q[`SCE_EN_LIGHT]))
    else $error("Light converter ran unpowered");
  irq_follow_a: assert property (prox_pend_q &&
    enable_q[`SCE_EN_PROX_IRQ] |=> irq_out)
    else $error("Interrupt output missed");
  write_cov: cover property (data_wr_ev && reg_addr_q == 5'h00);
  read_cov: cover property (rd_done_ev);
  clear_cov: cover property (clr_light && light_pend_q);
  ready_cov: cover property ($rose(meas_ready));

endmodule : sce_cmd_enable

`default_nettype wire

// ==== sce_host_model.sv ====
// Purpose: Serial-bus host model facing the command/enable block
// Assumes: Open-drain data line with pull-up, resolved by the bench
// Notes: A bit takes 8 sys_clk cycles (800 ns); acks and bytes reported
`timescale 1ns/1ps
`default_nettype none

module sce_host_model (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic got,
  output logic [7:0] got_val
);
  // Idle bus: clock stands high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got = 1'b0;
    got_val = 8'h00;
  end

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // One-cycle pulse hands a result to the bench monitor
  task automatic rep(logic [7:0] v);
    got_val <= v;
    got <= 1'b1;
    tick(1);
    got <= 1'b0;
  endtask : rep

  // Data moves only while the clock is low
  task automatic put(logic b);
    scl <= 1'b0;
    tick(3);
    sda_low <= !b;
    tick(1);
    scl <= 1'b1;
    tick(4);
  endtask : put

  // Sampled mid-high, far from the device's change at the fall
  task automatic take(output logic b);
    scl <= 1'b0;
    tick(3);
    sda_low <= 1'b0;
    tick(1);
    scl <= 1'b1;
    tick(2);
    b = sda;
    tick(2);
  endtask : take

  // Start and repeated start: data falls while the clock is high
  task automatic start();
    put(1'b1);
    sda_low <= 1'b1;
    tick(4);
  endtask : start

  // Stop: data rises while the clock is high
  task automatic stop();
    put(1'b0);
    sda_low <= 1'b0;
    tick(4);
  endtask : stop

  task automatic send(logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) put(v[i]);
    take(a);
    rep({7'h00, a});
  endtask : send

  // Last byte of a read is refused so the device lets go
  task automatic recv(logic nack);
    logic [7:0] v;
    logic b;
    for (int i = 7; i >= 0; i--) begin
      take(b);
      v[i] = b;
    end
    rep(v);
    put(nack);
  endtask : recv

  // Bytes go out from the top of v
  task automatic wr(int n, logic [31:0] v);
    start();
    for (int i = 0; i < n; i++) send(v[31-8*i -: 8]);
    stop();
  endtask : wr

  // Combined: command write, repeated start, n bytes read
  task automatic rd(logic [7:0] cmd, int n);
    start();
    send(8'h72);
    send(cmd);
    start();
    send(8'h73);
    for (int i = 0; i < n; i++) recv(i == n - 1);
    stop();
  endtask : rd
endmodule : sce_host_model

`default_nettype wire

// ==== sce_params.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included only by the command/enable module, not by the other design files
// Notes: Definitions only; guarded against double inclusion
`ifndef SCE_PARAMS_SVH
`define SCE_PARAMS_SVH

// Seven-bit target address on the serial bus
`define SCE_TARGET_ADDR 7'h39

// Register addresses (five-bit command address field)
`define SCE_ENABLE_ADDR 5'h00
`define SCE_STATUS_ADDR 5'h13

// Enable register reset value and writable bits (7:6 reserved)
`define SCE_ENABLE_RST 8'h00
`define SCE_ENABLE_MASK 8'h3f

// Enable register field positions
`define SCE_EN_PROX_IRQ 5
`define SCE_EN_LIGHT_IRQ 4
`define SCE_EN_WAIT 3
`define SCE_EN_PROX 2
`define SCE_EN_LIGHT 1
`define SCE_EN_OSC 0

// Status register field positions for the pending flags
`define SCE_ST_PROX_PEND 5
`define SCE_ST_LIGHT_PEND 4

// Command byte fields
`define SCE_CMD_SELECT 7
`define SCE_CMD_TYPE_HI 6
`define SCE_CMD_TYPE_LO 5

// Transfer type codes
`define SCE_TYPE_REPEAT 2'b00
`define SCE_TYPE_AUTOINC 2'b01
`define SCE_TYPE_RESERVED 2'b10
`define SCE_TYPE_SPECIAL 2'b11

// Special-function codes
`define SCE_SF_NONE 5'h00
`define SCE_SF_CLR_PROX 5'h05
`define SCE_SF_CLR_LIGHT 5'h06
`define SCE_SF_CLR_BOTH 5'h07

// Timing: power-up hold-off in ns and the system clock period in ns
`define SCE_HOLDOFF_NS 2720000
`define SCE_CLK_NS 100
// Least time, so round up to whole cycles
`define SCE_HOLDOFF_CYC \
  ((`SCE_HOLDOFF_NS + `SCE_CLK_NS - 1) / `SCE_CLK_NS)

`endif

// ==== sce_pkg.sv ====
// Purpose: Types shared by the command/enable block
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes: Constants live in sce_params.svh
package sce_pkg;

  // Serial-bus engine states
  typedef enum logic [2:0] {
    SCE_IDLE,
    SCE_RX,
    SCE_ACK,
    SCE_TX,
    SCE_TXACK
  } sce_bus_state_t;

endpackage : sce_pkg

// ==== sce_sync.sv ====
// Purpose: Two-flop synchroniser for one asynchronous input
// Assumes: Input comes from a pin outside the sys_clk domain
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module sce_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);

  // First stage may go metastable; nothing but stage two reads it
  logic meta_q;

  // Both stages reset to the idle bus level
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sce_sync

`default_nettype wire

// ==== test_sce_cmd_enable.sv ====
// Purpose: Self-checking bench for the command/enable block
// Assumes: 10 MHz sys_clk, host model on the serial pins
// Notes: Short hold-off parameter keeps the run brief
`timescale 1ns/1ps
`default_nettype none

module test_sce_cmd_enable;
  localparam int HO = 40;
  logic sys_clk, reset, prox_event, light_event, snap;
  logic [31:0] seed = 32'h9e72;
  logic [7:0] bus_q[$];
  logic [5:0] port_q[$];
  int failures = 0;
  int check_count = 0;
  wire scl, sda_low, sda_out, sda_oe, got;
  wire [7:0] got_val;
  wire osc_run, wait_run, prox_run, light_adc_run, meas_ready, irq_out;
  // Open drain with pull-up: low if either side pulls
  wire sda = !(sda_low || (sda_oe && !sda_out));
  wire [5:0] ports = {irq_out, meas_ready, light_adc_run, prox_run,
    wait_run, osc_run};

  sce_cmd_enable #(.HOLDOFF_CYC(HO)) sce_cmd_enable_inst (
    .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .prox_event(prox_event),
    .light_event(light_event), .osc_run(osc_run), .wait_run(wait_run),
    .prox_run(prox_run), .light_adc_run(light_adc_run),
    .meas_ready(meas_ready), .irq_out(irq_out));

  sce_host_model sce_host_model_inst (
    .sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
    .got(got), .got_val(got_val));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Monitor: each reported result is paired with the oldest note
  always @(posedge sys_clk) begin
    if (got === 1'b1) begin
      if (bus_q.size() == 0) check("bus extra", got_val, 8'hxx);
      else check("bus", got_val, bus_q.pop_front());
    end
    if (snap) begin
      if (port_q.size() == 0) check("port extra", 8'(ports), 8'hxx);
      else check("ports", 8'(ports), 8'(port_q.pop_front()));
    end
  end

  // Every byte acked except a refused address
  task automatic bus_wr(int n, logic [31:0] v, logic a0 = 1'b0);
    bus_q.push_back({7'h00, a0});
    for (int i = 1; i < n; i++) bus_q.push_back(8'h00);
    sce_host_model_inst.wr(n, v);
  endtask : bus_wr

  task automatic bus_rd(logic [7:0] cmd, int n, logic [15:0] e);
    repeat (3) bus_q.push_back(8'h00);
    bus_q.push_back(e[15:8]);
    if (n == 2) bus_q.push_back(e[7:0]);
    sce_host_model_inst.rd(cmd, n);
  endtask : bus_rd

  // Enable write: command 0x80 selects address 0, repeated byte
  task automatic wen(logic [7:0] d);
    bus_wr(3, {8'h72, 8'h80, d, 8'h00});
  endtask : wen

  task automatic expect_ports(logic [5:0] e);
    port_q.push_back(e);
    snap <= 1'b1;
    @(posedge sys_clk);
    snap <= 1'b0;
  endtask : expect_ports

  task automatic pulse(logic [1:0] p);
    prox_event <= p[1];
    light_event <= p[0];
    @(posedge sys_clk);
    prox_event <= 1'b0;
    light_event <= 1'b0;
    @(posedge sys_clk);
  endtask : pulse

  // Watchdog against a hung handshake; the run needs about 10000 cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end

  initial begin
    logic [7:0] left;
    reset = 1'b1;
    prox_event = 1'b0;
    light_event = 1'b0;
    snap = 1'b0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus_rd(8'h80, 1, 16'h0000);
    bus_wr(1, 32'h7480_0000, 1'b1);
    // Oscillator forced on mid-transfer with power bit clear
    fork
      wen(8'h0e);
      begin
        repeat (100) @(posedge sys_clk);
        expect_ports(6'h01);
      end
    join
    expect_ports(6'h00);
    wen(8'h0f);
    expect_ports(6'h01);
    repeat (HO + 10) @(posedge sys_clk);
    expect_ports(6'h1f);
    // One function at a time, each to its own run output
    for (int b = 1; b < 4; b++) begin
      wen(8'h01 | 8'(1 << b));
      expect_ports(6'h11 | 6'(1 << (4 - b)));
    end
    bus_wr(2, 32'h7205_0000);
    bus_rd(8'h80, 2, 16'h0505);
    bus_wr(4, 32'h72a0_030f);
    bus_rd(8'ha0, 2, 16'h0300);
    repeat (4) begin
      seed = xs(seed);
      wen(seed[7:0] & 8'h3f);
      bus_rd(8'h80, 1, {seed[7:0] & 8'h3f, 8'h00});
    end
    wen(8'h3f);
    repeat (HO + 10) @(posedge sys_clk);
    // Each clear code against both flags pending
    for (int k = 0; k < 3; k++) begin
      left = (k == 0) ? 8'h10 : (k == 1) ? 8'h20 : 8'h00;
      pulse(2'b11);
      expect_ports(6'h3f);
      bus_wr(2, 32'h72e0_0000);
      bus_rd(8'h93, 1, 16'h3000);
      bus_wr(2, {8'h72, 8'he5 + 8'(k), 16'h0000});
      bus_rd(8'h93, 1, {left, 8'h00});
      bus_wr(2, 32'h72e7_0000);
      expect_ports(6'h1f);
    end
    wen(8'h0f);
    pulse(2'b11);
    expect_ports(6'h1f);
    bus_rd(8'h93, 1, 16'h0000);
    repeat (4) @(posedge sys_clk);
    if (bus_q.size() != 0 || port_q.size() != 0)
      check("left", 8'h01, 8'h00);
    give_verdict();
  end
endmodule : test_sce_cmd_enable

`default_nettype wire
